// file: seprl_defines.svh
`ifndef SEPRL_DEFINES_SVH
`define SEPRL_DEFINES_SVH
// register byte offsets
`define SEPRL_REG_CTRL 8'h00
`define SEPRL_REG_START 8'h04
`define SEPRL_REG_COUNT 8'h08
`define SEPRL_REG_PGMTIME 8'h0c
`define SEPRL_REG_STATUS 8'h10
`define SEPRL_REG_POINTER 8'h14
`define SEPRL_REG_BAUDDIV 8'h18
`define SEPRL_REG_LASTDATA 8'h1c
// ctrl fields
`define SEPRL_CTRL_GO 0
`define SEPRL_CTRL_ODSEL 1
// status fields
`define SEPRL_ST_BOOT 0
`define SEPRL_ST_BUSY 1
`define SEPRL_ST_DONE 2
`define SEPRL_ST_OVR 3
// reset values, loader entry address and ready character
`define SEPRL_START_RST 16'hd000
`define SEPRL_COUNT_RST 16'h3000
`define SEPRL_ENTRY_ADDR 16'hbf00
`define SEPRL_READY_CHAR 8'hff
// timing: default program pulse 2 ms at 10 MHz
`define SEPRL_CLK_HZ 10000000
`define SEPRL_PGM_US 2000
`define SEPRL_PGM_CYC ((`SEPRL_PGM_US * (`SEPRL_CLK_HZ / 1000000)))
`define SEPRL_BAUD_RST 16'h0516
`endif

// file: seprl_pkg.sv
package seprl_pkg;
  typedef enum logic [2:0] {
    SP_IDLE, SP_READY, SP_WAIT, SP_PROG, SP_READ, SP_ECHO
  } seprl_state_t;
endpackage

// file: seprl_fifo.sv
`timescale 1ns/10ps
module seprl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q;
  logic [AW:0] rdPtr_q;
  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;
  assign inReady = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData = mem[rdPtr_q[AW-1:0]];
  always_ff @(posedge clk) begin
    if (doWrite) mem[wrPtr_q[AW-1:0]] <= inData;
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (doWrite) wrPtr_q <= wrPtr_q + 1'b1;
      if (doRead) rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule

// file: seprl_loader.sv
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "seprl_defines.svh"
// Functional notes
// - first byte after ready char goes to start address, then following addresses
// - byte count, start address and pulse time are software-adjustable with defaults
// - device opens exchange by sending all-ones ready character
// - each byte is programmed, held for pulse time, read back and echoed
// - bytes arriving during programming are held until the next pass
// - wait loop never ends by itself; host resets after last verify
// - pointer and parameters are loaded with defaults before the routine starts
// - mode inputs sampled only during reset; both low select bootstrap
// - open-drain select set at init; transmit pin only pulls low
// - all other serial port pins stay high-impedance inputs
module seprl_loader import seprl_pkg::*; #(
  parameter int PGM_CYCLES = `SEPRL_PGM_CYC,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // mode pins
  input wire logic modeSelectA,
  input wire logic modeSelectB,
  // serial port pins
  input wire logic serialReceivePin,
  output logic serialTransmitOut,
  output logic serialTransmitOe,
  output logic [5:0] portOtherOe,
  // memory write/read port
  output logic [15:0] memAddr,
  output logic [7:0] memWrData,
  output logic memPgm,
  output logic memRd,
  input wire logic [7:0] memRdData
);
  initial begin
    if (PGM_CYCLES < 1) $error("pulse time must be at least one cycle");
  end
  // reset release
  logic rstSync1_q, rstSync2_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  wire rstN = rstSync2_q;
  // mode pin synchronisers and latch while reset held
  logic modeA1_q, modeA2_q, modeB1_q, modeB2_q, bootMode_q;
  always_ff @(posedge core_clk) begin
    modeA1_q <= modeSelectA;
    modeA2_q <= modeA1_q;
    modeB1_q <= modeSelectB;
    modeB2_q <= modeB1_q;
  end
  always_ff @(posedge core_clk) begin
    if (!rstN) bootMode_q <= !modeA2_q && !modeB2_q;
  end
  // receive pin synchroniser
  logic rx1_q, rx2_q;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      rx1_q <= 1'b1;
      rx2_q <= 1'b1;
    end else begin
      rx1_q <= serialReceivePin;
      rx2_q <= rx1_q;
    end
  end
  // software registers
  logic goCtl_q, odSel_q, overrun_q;
  logic [15:0] startAddr_q, count_q, baudDiv_q, ptr_q;
  logic [31:0] pgmTime_q;
  logic [7:0] lastEcho_q;
  seprl_state_t state_q;
  wire wbReq = wbCyc && wbStb && !wbAck;
  wire wbWr = wbReq && wbWe && wbSel[0];
  wire selCtrl = wbAdr == `SEPRL_REG_CTRL;
  wire selStart = wbAdr == `SEPRL_REG_START;
  wire selCount = wbAdr == `SEPRL_REG_COUNT;
  wire selPgm = wbAdr == `SEPRL_REG_PGMTIME;
  wire selBaud = wbAdr == `SEPRL_REG_BAUDDIV;
  wire busy = state_q != SP_IDLE;
  wire [31:0] statusWord = {28'h0, overrun_q, ptr_q - startAddr_q == count_q && busy,
    busy, bootMode_q};
  logic [31:0] rdMux;
  always_comb begin
    case (wbAdr)
      `SEPRL_REG_CTRL: rdMux = {30'h0, odSel_q, goCtl_q};
      `SEPRL_REG_START: rdMux = {16'h0, startAddr_q};
      `SEPRL_REG_COUNT: rdMux = {16'h0, count_q};
      `SEPRL_REG_PGMTIME: rdMux = pgmTime_q;
      `SEPRL_REG_STATUS: rdMux = statusWord;
      `SEPRL_REG_POINTER: rdMux = {16'h0, ptr_q};
      `SEPRL_REG_BAUDDIV: rdMux = {16'h0, baudDiv_q};
      `SEPRL_REG_LASTDATA: rdMux = {24'h0, lastEcho_q};
      default: rdMux = 32'h0;
    endcase
  end
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      wbAck <= 1'b0;
      wbDatR <= 32'h0;
    end else begin
      wbAck <= wbReq;
      wbDatR <= wbReq ? rdMux : 32'h0;
    end
  end
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      goCtl_q <= 1'b0;
      odSel_q <= 1'b1;
      startAddr_q <= `SEPRL_START_RST;
      count_q <= `SEPRL_COUNT_RST;
      pgmTime_q <= 32'(PGM_CYCLES);
      baudDiv_q <= `SEPRL_BAUD_RST;
    end else if (wbWr && !busy) begin
      if (selCtrl) begin
        goCtl_q <= wbDatW[`SEPRL_CTRL_GO];
        odSel_q <= wbDatW[`SEPRL_CTRL_ODSEL];
      end
      if (selStart) startAddr_q <= wbDatW[15:0];
      if (selCount) count_q <= wbDatW[15:0];
      if (selPgm && wbDatW != 32'h0) pgmTime_q <= wbDatW;
      if (selBaud && wbDatW[15:0] != 16'h0) baudDiv_q <= wbDatW[15:0];
    end
  end
  // receiver: 8N1, baud counter in core cycles per bit
  logic [15:0] rxCnt_q;
  logic [3:0] rxBit_q;
  logic [7:0] rxShift_q;
  logic rxBusy_q, rxStrobe_q;
  wire [15:0] halfBit = {1'b0, baudDiv_q[15:1]};
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      rxBusy_q <= 1'b0;
      rxCnt_q <= 16'h0;
      rxBit_q <= 4'h0;
      rxShift_q <= 8'h0;
      rxStrobe_q <= 1'b0;
    end else begin
      rxStrobe_q <= 1'b0;
      if (!rxBusy_q) begin
        if (!rx2_q && busy) begin
          rxBusy_q <= 1'b1;
          rxCnt_q <= halfBit;
          rxBit_q <= 4'h0;
        end
      end else if (rxCnt_q != 16'h0) begin
        rxCnt_q <= rxCnt_q - 16'h1;
      end else begin
        rxCnt_q <= baudDiv_q - 16'h1;
        rxBit_q <= rxBit_q + 4'h1;
        if (rxBit_q == 4'h0 && rx2_q) rxBusy_q <= 1'b0;
        if (rxBit_q >= 4'h1 && rxBit_q <= 4'h8) rxShift_q <= {rx2_q, rxShift_q[7:1]};
        if (rxBit_q == 4'h9) begin
          rxBusy_q <= 1'b0;
          rxStrobe_q <= rx2_q;
        end
      end
    end
  end
  // receive fifo holds bytes arriving while programming
  logic fifoValid, fifoInReady, fifoPop;
  logic [7:0] fifoData;
  seprl_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rxFifo (
    .clk(core_clk),
    .rstN(rstN),
    .inValid(rxStrobe_q),
    .inReady(fifoInReady),
    .inData(rxShift_q),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) overrun_q <= 1'b0;
    else if (rxStrobe_q && !fifoInReady) overrun_q <= 1'b1;
  end
  // transmitter
  logic [9:0] txShift_q;
  logic [3:0] txBit_q;
  logic [15:0] txCnt_q;
  logic txBusy_q, txLoad;
  logic [7:0] txByte;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      txBusy_q <= 1'b0;
      txShift_q <= 10'h3ff;
      txBit_q <= 4'h0;
      txCnt_q <= 16'h0;
    end else if (txLoad) begin
      txBusy_q <= 1'b1;
      txShift_q <= {1'b1, txByte, 1'b0};
      txBit_q <= 4'h0;
      txCnt_q <= baudDiv_q - 16'h1;
    end else if (txBusy_q) begin
      if (txCnt_q != 16'h0) begin
        txCnt_q <= txCnt_q - 16'h1;
      end else begin
        txCnt_q <= baudDiv_q - 16'h1;
        txShift_q <= {1'b1, txShift_q[9:1]};
        txBit_q <= txBit_q + 4'h1;
        if (txBit_q == 4'h9) txBusy_q <= 1'b0;
      end
    end
  end
  // pin drive: open-drain drives only low
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      serialTransmitOut <= 1'b1;
      serialTransmitOe <= 1'b0;
      portOtherOe <= 6'h0;
    end else begin
      serialTransmitOut <= txShift_q[0];
      serialTransmitOe <= odSel_q ? !txShift_q[0] : busy;
      portOtherOe <= 6'h0;
    end
  end
  // programming sequencer
  logic [31:0] tmr_q;
  seprl_state_t stateD;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= SP_IDLE;
      ptr_q <= `SEPRL_START_RST;
      tmr_q <= 32'h0;
      lastEcho_q <= 8'h0;
      memAddr <= 16'h0;
      memWrData <= 8'h0;
      memPgm <= 1'b0;
      memRd <= 1'b0;
    end else begin
      state_q <= stateD;
      memPgm <= stateD == SP_PROG;
      memRd <= stateD == SP_READ;
      if (state_q == SP_IDLE) ptr_q <= startAddr_q;
      if (state_q == SP_WAIT && fifoValid) begin
        memAddr <= ptr_q;
        memWrData <= fifoData;
        tmr_q <= pgmTime_q - 32'h1;
      end
      if (state_q == SP_PROG) tmr_q <= tmr_q - 32'h1;
      if (state_q == SP_READ) lastEcho_q <= memRdData;
      if (state_q == SP_ECHO && !txBusy_q) ptr_q <= ptr_q + 16'h1;
    end
  end
  assign fifoPop = state_q == SP_WAIT && fifoValid;
  assign txLoad = (state_q == SP_READY || state_q == SP_ECHO) && !txBusy_q;
  assign txByte = state_q == SP_READY ? `SEPRL_READY_CHAR : lastEcho_q;
  always_comb begin
    case (state_q)
      SP_IDLE: stateD = (goCtl_q && bootMode_q) ? SP_READY : SP_IDLE;
      SP_READY: stateD = txBusy_q ? SP_READY : SP_WAIT;
      SP_WAIT: stateD = fifoValid ? SP_PROG : SP_WAIT;
      SP_PROG: stateD = tmr_q == 32'h0 ? SP_READ : SP_PROG;
      SP_READ: stateD = SP_ECHO;
      SP_ECHO: stateD = txBusy_q ? SP_ECHO : SP_WAIT;
      default: stateD = SP_IDLE;
    endcase
  end
  // checks
  // helper: length of the running program strobe
  logic [31:0] pgmRun_q;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) pgmRun_q <= 32'h0;
    else if (memPgm) pgmRun_q <= pgmRun_q + 32'h1;
    else pgmRun_q <= 32'h0;
  end
  // pulse over, then one read, then echo
  sequence s_prog_last;
    state_q == SP_PROG && tmr_q == 32'h0;
  endsequence
  sequence s_read_echo;
    memRd && !memPgm ##1 state_q == SP_ECHO;
  endsequence
  a_pulse_length: assert property (@(posedge core_clk) disable iff (!rstN)
    $fell(memPgm) |-> pgmRun_q == pgmTime_q)
    else $error("program strobe length wrong");
  a_prog_read: assert property (@(posedge core_clk) disable iff (!rstN)
    s_prog_last |=> s_read_echo)
    else $error("readback does not follow pulse");
  a_echo_frame: assert property (@(posedge core_clk) disable iff (!rstN)
    (state_q == SP_ECHO && !txBusy_q) |=> txBusy_q && txShift_q == {1'b1, lastEcho_q, 1'b0})
    else $error("echo frame not loaded");
  a_pointer_step: assert property (@(posedge core_clk) disable iff (!rstN)
    (state_q == SP_ECHO && stateD == SP_WAIT) |=> ptr_q == $past(ptr_q) + 16'h1)
    else $error("pointer did not advance by one");
  a_ptr_hold: assert property (@(posedge core_clk) disable iff (!rstN)
    (state_q != SP_IDLE && !(state_q == SP_ECHO && !txBusy_q)) |=> $stable(ptr_q))
    else $error("pointer moved outside echo");
  a_open_drain: assert property (@(posedge core_clk) disable iff (!rstN)
    (odSel_q && serialTransmitOe) |-> !serialTransmitOut)
    else $error("open drain drove high");
  a_line_idle: assert property (@(posedge core_clk) disable iff (!rstN)
    !txBusy_q |-> txShift_q == 10'h3ff)
    else $error("transmit line not idle high");
  a_others_hiz: assert property (@(posedge core_clk) disable iff (!rstN)
    portOtherOe == 6'h0)
    else $error("port pin driven");
  a_ready_first: assert property (@(posedge core_clk) disable iff (!rstN)
    (state_q == SP_IDLE && goCtl_q && bootMode_q) |=> ##1 (txBusy_q &&
      txShift_q == {1'b1, `SEPRL_READY_CHAR, 1'b0}))
    else $error("ready char wrong");
  a_no_overflow_drop: assert property (@(posedge core_clk) disable iff (!rstN)
    (rxStrobe_q && fifoInReady) |=> fifoValid)
    else $error("byte lost");
  a_rx_held: assert property (@(posedge core_clk) disable iff (!rstN)
    (state_q == SP_PROG && fifoValid) |=> fifoValid)
    else $error("held byte dropped while programming");
  a_overrun_sticky: assert property (@(posedge core_clk) disable iff (!rstN)
    overrun_q |=> overrun_q)
    else $error("overrun flag cleared");
  a_wait_holds: assert property (@(posedge core_clk) disable iff (!rstN)
    (state_q == SP_WAIT && !fifoValid) |=> state_q == SP_WAIT)
    else $error("wait loop left");
  a_read_echo: assert property (@(posedge core_clk) disable iff (!rstN)
    state_q == SP_READ |=> lastEcho_q == $past(memRdData))
    else $error("echo not readback");
  a_start_addr: assert property (@(posedge core_clk) disable iff (!rstN)
    (state_q == SP_IDLE) |=> ptr_q == $past(startAddr_q))
    else $error("pointer not at start");
  a_busy_refuse: assert property (@(posedge core_clk) disable iff (!rstN)
    (wbWr && busy) |=> $stable(startAddr_q) && $stable(count_q) && $stable(pgmTime_q))
    else $error("setting changed while busy");
  a_mode_latched: assert property (@(posedge core_clk) disable iff (!rstN)
    rstN |=> $stable(bootMode_q))
    else $error("mode changed out of reset");
  a_ack_pulse: assert property (@(posedge core_clk) disable iff (!rstN)
    wbAck |=> !wbAck)
    else $error("ack longer than one cycle");
endmodule

// file: seprl_host.sv
`timescale 1ns/10ps
module seprl_host #(
  parameter int BIT = 16
) (
  // clock
  input wire logic clk,
  // serial lines
  output logic rxLine,
  input wire logic txLine
);
  logic [7:0] dataQ[$];
  logic [7:0] echoQ[$];
  logic [7:0] readyByte;
  int got;
  initial rxLine = 1'b1;
  // 8n1 frame, lsb first, idle high
  task automatic sendByte(input logic [7:0] b);
    rxLine <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rxLine <= b[i];
      repeat (BIT) @(posedge clk);
    end
    rxLine <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  task automatic recvByte(output logic [7:0] b);
    while (txLine !== 1'b0) @(posedge clk);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      b[i] = txLine;
    end
    repeat (BIT) @(posedge clk);
  endtask
  // loader program itself not modelled, go bit starts the routine
  // two bytes ahead, then one more per echo
  task automatic session(input int n);
    logic [7:0] b;
    got = 0;
    echoQ = {};
    recvByte(readyByte);
    fork
      for (int k = 0; k < n; k++) begin
        wait (got >= k - 1);
        sendByte(dataQ[k]);
      end
      for (int k = 0; k < n; k++) begin
        recvByte(b);
        echoQ.push_back(b);
        got++;
      end
    join
  endtask
endmodule

// file: tb_serial_eprom_program_loader.sv
`timescale 1ns/10ps
`include "seprl_defines.svh"
module tb_serial_eprom_program_loader;
  localparam int BIT = 16;
  logic core_clk, rst_n, wbCyc, wbStb, wbWe, wbAck, modeSelectA, modeSelectB;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR, rd;
  logic serialReceivePin, serialTransmitOut, serialTransmitOe, txWire, memPgm, memRd, pgmPrev;
  logic [5:0] portOtherOe;
  logic [15:0] memAddr;
  logic [7:0] memWrData, memRdData;
  logic [7:0] mem [0:65535];
  logic [15:0] addrQ[$];
  int fails, nCompared, pgmCnt, pgmLen;

  seprl_loader #(.PGM_CYCLES(40), .FIFO_DEPTH(16)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
    .modeSelectA(modeSelectA), .modeSelectB(modeSelectB),
    .serialReceivePin(serialReceivePin), .serialTransmitOut(serialTransmitOut),
    .serialTransmitOe(serialTransmitOe), .portOtherOe(portOtherOe), .memAddr(memAddr),
    .memWrData(memWrData), .memPgm(memPgm), .memRd(memRd), .memRdData(memRdData));
  // pull-up on the open-drain transmit line
  assign txWire = serialTransmitOe ? serialTransmitOut : 1'b1;
  assign memRdData = mem[memAddr];
  seprl_host #(.BIT(BIT)) u_host (.clk(core_clk), .rxLine(serialReceivePin), .txLine(txWire));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // memory model and pulse monitor
  always @(posedge core_clk) begin
    pgmPrev <= memPgm;
    if (memPgm) begin
      mem[memAddr] <= memWrData;
      pgmCnt <= pgmCnt + 1;
    end else if (pgmPrev) begin
      pgmLen <= pgmCnt;
      pgmCnt <= 0;
    end
    if (memPgm && !pgmPrev) addrQ.push_back(memAddr);
    if (memRd) check(memAddr, addrQ[$]);
    if (serialTransmitOe === 1'b1 && serialTransmitOut !== 1'b0) check(1, 0);
    if (portOtherOe !== 6'h00) check(portOtherOe, 0);
  end

  task automatic wbXfer(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= d;
    wbSel <= 4'hf;
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'b1);
    // ack one cycle after the request is taken
    check(n, 2);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge core_clk);
  endtask

  task doReset(input logic a, input logic b);
    rst_n <= 1'b0;
    modeSelectA <= a;
    modeSelectB <= b;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic runSession(input int n, input logic [15:0] base, input int pt);
    addrQ = {};
    fork
      u_host.session(n);
      wbXfer(`SEPRL_REG_CTRL, 1'b1, 32'h3);
    join
    check(u_host.readyByte, `SEPRL_READY_CHAR);
    for (int k = 0; k < n; k++) begin
      check(u_host.echoQ[k], u_host.dataQ[k]);
      check(addrQ[k], base + k);
    end
    check(pgmLen, pt);
    wbXfer(`SEPRL_REG_POINTER, 1'b0, 0);
    check(rd[15:0], base + n);
  endtask

  task printVerdict;
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatW = 32'h0;
    fails = 0;
    nCompared = 0;
    pgmCnt = 0;
    pgmPrev = 1'b0;
    // mode pins not both low: go must not start the routine
    doReset(1'b1, 1'b0);
    wbXfer(`SEPRL_REG_CTRL, 1'b1, 32'h3);
    repeat (50) @(posedge core_clk);
    wbXfer(`SEPRL_REG_STATUS, 1'b0, 0);
    check(rd[1:0], 0);
    doReset(1'b0, 1'b0);
    // mode pins ignored once out of reset
    modeSelectA <= 1'b1;
    wbXfer(`SEPRL_REG_CTRL, 1'b0, 0);
    check(rd[1], 1);
    wbXfer(`SEPRL_REG_STATUS, 1'b0, 0);
    check(rd[0], 1);
    wbXfer(`SEPRL_REG_START, 1'b0, 0);
    check(rd[15:0], 16'hd000);
    wbXfer(`SEPRL_REG_COUNT, 1'b0, 0);
    check(rd[15:0], 16'h3000);
    wbXfer(`SEPRL_REG_BAUDDIV, 1'b0, 0);
    check(rd[15:0], 16'h0516);
    wbXfer(8'h20, 1'b0, 0);
    check(rd, 0);
    wbXfer(`SEPRL_REG_BAUDDIV, 1'b1, BIT);
    u_host.dataQ = '{8'h5a, 8'ha5, 8'h00};
    runSession(3, 16'hd000, 40);
    wbXfer(`SEPRL_REG_STATUS, 1'b0, 0);
    check(rd[1], 1);
    check(rd[3:2], 0);
    wbXfer(`SEPRL_REG_START, 1'b1, 32'h0100);
    wbXfer(`SEPRL_REG_START, 1'b0, 0);
    check(rd[15:0], 16'hd000);
    wbXfer(`SEPRL_REG_LASTDATA, 1'b0, 0);
    check(rd[7:0], 8'h00);
    // only reset ends the wait loop
    doReset(1'b0, 1'b0);
    wbXfer(`SEPRL_REG_STATUS, 1'b0, 0);
    check(rd[1], 0);
    wbXfer(`SEPRL_REG_BAUDDIV, 1'b1, BIT);
    wbXfer(`SEPRL_REG_START, 1'b1, 32'h0120);
    // pulse longer than a byte time, so a byte waits in the fifo
    wbXfer(`SEPRL_REG_PGMTIME, 1'b1, 32'hc8);
    wbXfer(`SEPRL_REG_COUNT, 1'b1, 32'h5);
    u_host.dataQ = '{8'hff, 8'h01, 8'h80, 8'h3c, 8'hc3};
    runSession(5, 16'h0120, 200);
    wbXfer(`SEPRL_REG_STATUS, 1'b0, 0);
    check(rd[2], 1);
    check(rd[3], 0);
    printVerdict;
  end

  initial begin
    repeat (30000) @(posedge core_clk);
    fails++;
    printVerdict;
  end
endmodule
